// *** rtl/dbg_pin_pkg.sv ***
// constants for the debug pin override control block
`default_nettype none
package dbg_pin_pkg;
  localparam logic [31:0] cfg_addr = 32'h4000_bc00;
  localparam logic [31:0] stat_addr = 32'h4000_bc04;
  localparam logic [31:0] cfg_reset = 32'h0000_0010;
  localparam logic [31:0] stat_reset = 32'h0000_0000;
  localparam int unsigned cfg_dis_bit = 5;
  localparam int unsigned cfg_reg_bit = 4;
  localparam int unsigned cfg_rsvd_bit = 3;
  localparam int unsigned stat_boot_bit = 3;
  localparam int unsigned stat_forced_bit = 1;
  localparam int unsigned stat_sw_bit = 0;
  localparam int unsigned sync_stages = 2;
endpackage
`default_nettype wire

// *** rtl/level_sync.sv ***
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter logic reset_value = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  always_comb begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_q <= reset_value;
      sync_q <= reset_value;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule // level_sync
`default_nettype wire

// *** rtl/debug_pin_override_ctrl.sv ***
// apb register block for debug pin override control and status
`timescale 1ns/1ps
`default_nettype none
module debug_pin_override_ctrl
  import dbg_pin_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_strap_pin_n,
  input wire logic debug_cable_force,
  input wire logic serial_wire_enable,
  input wire logic debug_active,
  input wire logic rsvd_hw_set,
  input wire logic rsvd_hw_value,
  output logic debug_override_permit,
  output logic regulator_enable_override
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic boot_s;
  logic forced_s;
  logic sw_s;
  level_sync #(.reset_value(1'b1)) u_boot (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .async_in(boot_strap_pin_n), .sync_out(boot_s));
  level_sync u_forced (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .async_in(debug_cable_force), .sync_out(forced_s));
  level_sync u_sw (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .async_in(serial_wire_enable), .sync_out(sw_s));

  // ************************************************************
  // register state
  // ************************************************************
  logic dis_q, dis_d;
  logic regen_q, regen_d;
  logic rsvd_q, rsvd_d;
  logic boot_q, boot_d;
  logic cap_done_q, cap_done_d;
  logic [1:0] cap_cnt_q, cap_cnt_d;
  logic forced_q, forced_d;
  logic sw_q, sw_d;
  logic dbg_held_q, dbg_held_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_cfg;
  logic rd_access;

  assign wr_cfg = psel && penable && pwrite && (paddr == cfg_addr);
  assign rd_access = psel && !penable && !pwrite;

  always_comb begin
    dis_d = dis_q;
    regen_d = regen_q;
    rsvd_d = rsvd_q;
    boot_d = boot_q;
    cap_done_d = cap_done_q;
    cap_cnt_d = cap_cnt_q;
    forced_d = forced_s;
    sw_d = sw_s;
    dbg_held_d = dbg_held_q;
    rdata_d = rdata_q;
    if (wr_cfg) begin
      dis_d = pwdata[cfg_dis_bit];
      regen_d = pwdata[cfg_reg_bit];
      rsvd_d = pwdata[cfg_rsvd_bit];
    end
    if (rsvd_hw_set) begin
      rsvd_d = rsvd_hw_value;
    end
    // strap sampled once the synchroniser holds the pin level after reset release
    if (!cap_done_q) begin
      if (cap_cnt_q == 2'(sync_stages)) begin
        boot_d = !boot_s;
        cap_done_d = 1'b1;
      end else begin
        cap_cnt_d = cap_cnt_q + 2'h1;
      end
    end
    // debug that is already active stays active despite disable
    dbg_held_d = debug_active && (dbg_held_q || !dis_q);
    if (rd_access) begin
      rdata_d = 32'h0000_0000;
      if (paddr == cfg_addr) begin
        rdata_d[cfg_dis_bit] = dis_q;
        rdata_d[cfg_reg_bit] = regen_q;
        rdata_d[cfg_rsvd_bit] = rsvd_q;
      end else if (paddr == stat_addr) begin
        rdata_d[stat_boot_bit] = boot_q;
        rdata_d[stat_forced_bit] = forced_q;
        rdata_d[stat_sw_bit] = sw_q;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dis_q <= cfg_reset[cfg_dis_bit];
      regen_q <= cfg_reset[cfg_reg_bit];
      rsvd_q <= cfg_reset[cfg_rsvd_bit];
      boot_q <= stat_reset[stat_boot_bit];
      cap_done_q <= 1'b0;
      cap_cnt_q <= 2'h0;
      forced_q <= stat_reset[stat_forced_bit];
      sw_q <= stat_reset[stat_sw_bit];
      dbg_held_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      dis_q <= dis_d;
      regen_q <= regen_d;
      rsvd_q <= rsvd_d;
      boot_q <= boot_d;
      cap_done_q <= cap_done_d;
      cap_cnt_q <= cap_cnt_d;
      forced_q <= forced_d;
      sw_q <= sw_d;
      dbg_held_q <= dbg_held_d;
      rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr != cfg_addr) && (paddr != stat_addr);
  assign debug_override_permit = !dis_q || dbg_held_q;
  assign regulator_enable_override = regen_q;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_cfg_write;
    psel && penable && pwrite && paddr == cfg_addr && clk_en && !rsvd_hw_set;
  endsequence
  property p_dis_write;
    @(posedge ref_clk) disable iff (reset)
    s_cfg_write |=> dis_q == $past(pwdata[cfg_dis_bit]);
  endproperty
  a_dis_write: assert property (p_dis_write) else $error("disable bit not stored");
  property p_permit;
    @(posedge ref_clk) disable iff (reset)
    clk_en && debug_active && !dis_q |=> debug_override_permit;
  endproperty
  a_permit: assert property (p_permit) else $error("override not permitted");
  property p_regen;
    @(posedge ref_clk) disable iff (reset)
    s_cfg_write |=> regulator_enable_override == $past(pwdata[cfg_reg_bit]);
  endproperty
  a_regen: assert property (p_regen) else $error("regulator override wrong");
  property p_rsvd_hw;
    @(posedge ref_clk) disable iff (reset)
    rsvd_hw_set && clk_en |=> rsvd_q == $past(rsvd_hw_value);
  endproperty
  a_rsvd_hw: assert property (p_rsvd_hw) else $error("reserved bit hw update lost");
  property p_boot_stable;
    @(posedge ref_clk) disable iff (reset)
    cap_done_q |=> $stable(boot_q);
  endproperty
  a_boot_stable: assert property (p_boot_stable) else $error("boot state changed");
  property p_forced;
    @(posedge ref_clk) disable iff (reset)
    clk_en |=> forced_q == $past(forced_s);
  endproperty
  a_forced: assert property (p_forced) else $error("forced flag lag wrong");
  property p_sw;
    @(posedge ref_clk) disable iff (reset)
    clk_en |=> sw_q == $past(sw_s);
  endproperty
  a_sw: assert property (p_sw) else $error("serial wire flag lag wrong");
  property p_rd_zero;
    @(posedge ref_clk) disable iff (reset)
    rd_access && clk_en |=> prdata[31:6] == 26'h0 && prdata[2] == 1'b0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("undefined bits nonzero");
  sequence s_cfg_read;
    psel && !penable && !pwrite && paddr == cfg_addr && clk_en;
  endsequence
  sequence s_stat_read;
    psel && !penable && !pwrite && paddr == stat_addr && clk_en;
  endsequence
  property p_held_drop;
    @(posedge ref_clk) disable iff (reset)
    clk_en && !debug_active |=> debug_override_permit == !dis_q;
  endproperty
  a_held_drop: assert property (p_held_drop) else $error("override kept without debug");
  property p_rsvd_write;
    @(posedge ref_clk) disable iff (reset)
    s_cfg_write |=> rsvd_q == $past(pwdata[cfg_rsvd_bit]);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write) else $error("reserved bit not stored");
  property p_boot_capture;
    @(posedge ref_clk) disable iff (reset)
    clk_en && !cap_done_q && cap_cnt_q == 2'(sync_stages) |=> boot_q == !$past(boot_s);
  endproperty
  a_boot_capture: assert property (p_boot_capture) else $error("strap capture wrong");
  property p_rd_cfg;
    @(posedge ref_clk) disable iff (reset)
    s_cfg_read |=> prdata[cfg_dis_bit] == $past(dis_q) && prdata[cfg_reg_bit] == $past(regen_q)
      && prdata[cfg_rsvd_bit] == $past(rsvd_q) && prdata[1:0] == 2'h0;
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read data wrong");
  property p_rd_stat;
    @(posedge ref_clk) disable iff (reset)
    s_stat_read |=> prdata[stat_boot_bit] == $past(boot_q)
      && prdata[stat_forced_bit] == $past(forced_q) && prdata[stat_sw_bit] == $past(sw_q);
  endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("status read data wrong");
  property p_stat_zero;
    @(posedge ref_clk) disable iff (reset)
    s_stat_read |=> prdata[5:4] == 2'h0;
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status spare bits nonzero");
endmodule // debug_pin_override_ctrl
`default_nettype wire

// *** testbench/probe_model.sv ***
// debug probe and boot strap pin model
`timescale 1ns/1ps
`default_nettype none
module probe_model (
  input wire logic strap_low,
  input wire logic cable_on,
  input wire logic swd_on,
  output logic boot_strap_pin_n,
  output logic debug_cable_force,
  output logic serial_wire_enable
);
  assign boot_strap_pin_n = !strap_low;
  assign debug_cable_force = cable_on;
  assign serial_wire_enable = swd_on;
endmodule // probe_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the debug pin override block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dbg_pin_pkg::*;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, r;
  logic strap_low, cable_on, swd_on, pin_n, cable, swd;
  logic debug_active, rsvd_hw_set, rsvd_hw_value, permit, regen, clk_en;
  int num_errors = 0;
  int num_checks = 0;
  probe_model i_probe (.strap_low(strap_low), .cable_on(cable_on), .swd_on(swd_on),
    .boot_strap_pin_n(pin_n), .debug_cable_force(cable), .serial_wire_enable(swd));
  debug_pin_override_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_strap_pin_n(pin_n),
    .debug_cable_force(cable), .serial_wire_enable(swd), .debug_active(debug_active),
    .rsvd_hw_set(rsvd_hw_set), .rsvd_hw_value(rsvd_hw_value),
    .debug_override_permit(permit), .regulator_enable_override(regen));
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ****************
  // bus and check tasks
  // ****************
  task automatic chk(input logic [31:0] g, x);
    num_checks++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
    r = prdata; e = pslverr;
    if (n >= 50) chk(1'b0, 1'b1);
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [31:0] a, x);
    xfer(0, a, 0);
    chk(r, x);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic do_reset(input logic s);
    strap_low <= s; reset <= 1;
    w(4);
    reset <= 0;
    w(5);
  endtask
  task automatic final_report;
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset_values;
    do_reset(1);
    rd(stat_addr, 32'h0000_0008);
    rd(cfg_addr, cfg_reset);
    chk(regen, 1);
    chk(permit, 1);
  endtask
  task automatic t_write_read;
    xfer(1, cfg_addr, 32'hFFFF_FFF7);
    chk(e, 0);
    rd(cfg_addr, 32'h0000_0030);
    chk(permit, 0);
    xfer(1, stat_addr, 32'hFFFF_FFFF);
    chk(e, 0);
    rd(stat_addr, 32'h0000_0008);
    xfer(1, cfg_addr, 0);
    rd(cfg_addr, 0);
    chk(regen, 0);
  endtask
  task automatic t_reserved_bit;
    rsvd_hw_set <= 1; rsvd_hw_value <= 1;
    w(1);
    rsvd_hw_set <= 0;
    rd(cfg_addr, 32'h0000_0008);
    xfer(1, cfg_addr, r | 32'h0000_0010);
    rd(cfg_addr, 32'h0000_0018);
  endtask
  task automatic t_unmapped;
    xfer(0, cfg_addr + 8, 0);
    chk(e, 1);
    chk(r, 0);
    xfer(1, cfg_addr + 8, 32'hFFFF_FFFF);
    chk(e, 1);
    rd(cfg_addr, 32'h0000_0018);
  endtask
  task automatic t_debug_hold;
    w(2);
    chk(permit, 1);
    xfer(1, cfg_addr, 32'h0000_0038);
    debug_active <= 1;
    w(2);
    chk(permit, 0);
    xfer(1, cfg_addr, 32'h0000_0018);
    xfer(1, cfg_addr, 32'h0000_0038);
    w(2);
    chk(permit, 1);
    debug_active <= 0;
    w(2);
    chk(permit, 0);
  endtask
  task automatic t_status_flags;
    cable_on <= 1;
    w(5);
    rd(stat_addr, 32'h0000_000A);
    cable_on <= 0; swd_on <= 1;
    w(5);
    rd(stat_addr, 32'h0000_0009);
  endtask
  task automatic t_freeze;
    clk_en <= 0;
    xfer(1, cfg_addr, 32'h0000_0008);
    w(3);
    clk_en <= 1;
    rd(cfg_addr, 32'h0000_0038);
    chk(regen, 1);
    chk(permit, 0);
  endtask
  task automatic t_strap_high;
    do_reset(0);
    rd(stat_addr, 32'h0000_0001);
    rd(cfg_addr, cfg_reset);
  endtask
  initial begin
    reset = 1; clk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    strap_low = 1; cable_on = 0; swd_on = 0;
    debug_active = 0; rsvd_hw_set = 0; rsvd_hw_value = 0;
    t_reset_values;
    t_write_read;
    t_reserved_bit;
    t_unmapped;
    t_debug_hold;
    t_status_flags;
    t_freeze;
    t_strap_high;
    final_report;
  end
  initial begin
    #20us;
    num_errors++;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
